/* hw/cbc_pkg.sv */
package cbc_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [11:0] CBC_OFF_CTRL = 12'h000;
  localparam logic [11:0] CBC_OFF_CMD = 12'h004;
  localparam logic [11:0] CBC_OFF_LEN = 12'h008;
  localparam logic [11:0] CBC_OFF_STAT = 12'h00C;
  localparam logic [11:0] CBC_OFF_BYTES = 12'h010;
  localparam logic [11:0] CBC_OFF_RDADDR = 12'h014;
  localparam logic [11:0] CBC_OFF_RDDATA = 12'h018;
  localparam logic [11:0] CBC_OFF_RATE = 12'h01C;

  // Field positions.
  localparam int CBC_CMD_START_BIT = 0;
  localparam int CBC_CMD_STOP_BIT = 1;
  localparam int CBC_CTRL_CIRC_BIT = 0;
  localparam int CBC_CTRL_MODE_LSB = 1;
  localparam int CBC_CTRL_CFG_LSB = 3;
  localparam int CBC_CTRL_DIV_LSB = 5;

  // Geometry and limits.
  localparam int CBC_BYTES_PER_POINT = 4;
  localparam int CBC_POINTS_PER_BLOCK = 512;
  localparam int CBC_BLOCK_KB = 2;
  localparam logic [12:0] CBC_LEN_MIN_KB = 13'h0001;
  localparam logic [12:0] CBC_LEN_MAX_KB = 13'h1000;
  localparam logic [12:0] CBC_LEN_RST_KB = 13'h0002;
  localparam logic [4:0] CBC_DIV_MAX = 5'h14;
  localparam real CBC_RATE_MAX_HZ = 1.25e6;

  // Acquisition start modes.
  typedef enum logic [1:0] {
    CBC_MODE_IMM = 2'b00,
    CBC_MODE_TRIG = 2'b01,
    CBC_MODE_SPT = 2'b10
  } cbc_mode_t;

  typedef enum logic [1:0] {
    CBC_ST_IDLE = 2'b00,
    CBC_ST_ARMED = 2'b01,
    CBC_ST_REC = 2'b10,
    CBC_ST_FILL = 2'b11
  } cbc_state_t;

  typedef struct packed {
    logic recording;
    logic triggered;
    logic wrapped;
  } cbc_status_t;

  // One simultaneous sample set of up to four parameters.
  typedef struct packed {
    logic [3:0][31:0] word;
  } cbc_sample_t;

endpackage

/* hw/cbc_capture_ctrl.sv */
`timescale 1ns/1ps
module cbc_capture_ctrl #(
  parameter int DEPTH_WORDS = 1048576
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Sample source.
  input wire logic max_rate_stb_i,
  input wire cbc_pkg::cbc_sample_t sample_i,
  input wire logic external_trigger_input_i,
  // Status.
  output cbc_pkg::cbc_status_t status_o
);
  import cbc_pkg::*;

  localparam int AW = $clog2(DEPTH_WORDS);

  typedef struct packed {
    cbc_state_t st;
    logic circ;
    cbc_mode_t mode;
    logic [1:0] cfg;
    logic [4:0] div;
    logic [12:0] len_kb;
    logic [AW-1:0] wptr;
    logic [2:0] par;
    logic [20:0] rate_cnt;
    logic [23:0] bytes;
    logic trig_d;
    logic pend;
    cbc_sample_t hold;
    logic rec;
    logic trg;
    logic wrp;
    logic [AW-1:0] rd_addr;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } cbc_regs_t;

  cbc_regs_t r_q;
  cbc_regs_t r_d;
  logic [31:0] mem_q [DEPTH_WORDS];
  logic mem_we;
  logic [AW-1:0] mem_wa;
  logic [31:0] mem_wd;

  logic apb_acc;
  logic wr_en;
  logic rd_en;
  logic fall;
  logic [AW:0] len_words;
  logic [2:0] npar;
  logic blk_end;
  logic buf_end;
  logic tick;
  logic [12:0] len_in;

  // Access completes one cycle after penable rises so pready stays a flop.
  assign apb_acc = psel_i && penable_i && !r_q.pready;
  assign wr_en = apb_acc && pwrite_i;
  assign rd_en = apb_acc && !pwrite_i;
  assign fall = r_q.trig_d && !external_trigger_input_i;
  assign len_words = (AW + 1)'({r_q.len_kb, 8'h00});
  assign npar = (r_q.cfg == 2'b00) ? 3'h1 : (r_q.cfg == 2'b11) ? 3'h4 : 3'h2;
  assign blk_end = &r_q.wptr[8:0];
  assign buf_end = ((AW + 1)'(r_q.wptr) + 1'b1) >= len_words;
  // Periodic tick is the max-rate strobe divided by 2^div; it follows the strobe at once.
  assign tick = max_rate_stb_i && ((r_q.rate_cnt & ((21'h1 << r_q.div) - 21'h1)) == 21'h0);
  // Odd length rounds up, values clamp into 2..4096.
  assign len_in = (pwdata_i[12:0] < CBC_LEN_MIN_KB) ? CBC_LEN_MIN_KB + 13'h1 :
                  (pwdata_i[31:13] != 19'h0 || pwdata_i[12:0] > CBC_LEN_MAX_KB) ? CBC_LEN_MAX_KB :
                  pwdata_i[12:0] + {12'h0, pwdata_i[0]};

  // Next-state logic for the whole block.
  always_comb begin
    r_d = r_q;
    mem_we = 1'b0;
    mem_wa = r_q.wptr;
    mem_wd = 32'h0;
    r_d.trig_d = external_trigger_input_i;
    r_d.pready = apb_acc;
    r_d.pslverr = 1'b0;
    if (max_rate_stb_i) begin
      r_d.rate_cnt = r_q.rate_cnt + 21'h1;
    end
    // Register writes.
    if (wr_en) begin
      case (paddr_i)
        CBC_OFF_CTRL: begin
          if (r_q.st == CBC_ST_IDLE) begin
            r_d.circ = pwdata_i[CBC_CTRL_CIRC_BIT];
            r_d.mode = cbc_mode_t'(pwdata_i[CBC_CTRL_MODE_LSB +: 2]);
            r_d.cfg = pwdata_i[CBC_CTRL_CFG_LSB +: 2];
            r_d.div = (pwdata_i[CBC_CTRL_DIV_LSB +: 5] > CBC_DIV_MAX) ? CBC_DIV_MAX
                      : pwdata_i[CBC_CTRL_DIV_LSB +: 5];
            r_d.trg = 1'b0;
            r_d.wrp = 1'b0;
          end
        end
        CBC_OFF_LEN: begin
          if (r_q.st == CBC_ST_IDLE) begin
            r_d.len_kb = len_in;
            r_d.trg = 1'b0;
            r_d.wrp = 1'b0;
          end
        end
        CBC_OFF_RDADDR: r_d.rd_addr = AW'(pwdata_i);
        CBC_OFF_CMD: begin
          if (pwdata_i[CBC_CMD_START_BIT]) begin
            // A new start discards the previous capture.
            r_d.wptr = '0;
            r_d.bytes = 24'h0;
            r_d.trg = 1'b0;
            r_d.wrp = 1'b0;
            r_d.par = 3'h0;
            r_d.pend = 1'b0;
            r_d.rate_cnt = 21'h0;
            r_d.st = (r_q.mode == CBC_MODE_IMM || (r_q.mode == CBC_MODE_TRIG && r_q.circ))
                     ? CBC_ST_REC : CBC_ST_ARMED;
            r_d.rec = r_d.st == CBC_ST_REC;
            r_d.trg = r_d.rec;
          end else if (pwdata_i[CBC_CMD_STOP_BIT]) begin
            if (r_q.st == CBC_ST_ARMED && r_q.mode != CBC_MODE_SPT) begin
              r_d.st = CBC_ST_IDLE;
            end else if (r_q.st == CBC_ST_REC || r_q.st == CBC_ST_ARMED) begin
              r_d.st = CBC_ST_FILL;
            end
          end
        end
        default: r_d.pslverr = 1'b0;
      endcase
    end
    // Register reads; status and count stay live during capture.
    if (rd_en) begin
      case (paddr_i)
        CBC_OFF_CTRL: r_d.prdata = {22'h0, r_q.div, r_q.cfg, r_q.mode, r_q.circ};
        CBC_OFF_LEN: r_d.prdata = {19'h0, r_q.len_kb};
        CBC_OFF_STAT: r_d.prdata = {29'h0, r_q.wrp, r_q.trg, r_q.rec};
        CBC_OFF_BYTES: r_d.prdata = {8'h0, r_q.bytes};
        CBC_OFF_RDADDR: r_d.prdata = 32'(r_q.rd_addr);
        CBC_OFF_RDDATA: r_d.prdata = mem_q[r_q.rd_addr];
        CBC_OFF_RATE: r_d.prdata = {27'h0, r_q.div};
        default: begin
          r_d.prdata = 32'h0;
          r_d.pslverr = 1'b1;
        end
      endcase
    end else if (wr_en && !(paddr_i inside {CBC_OFF_CTRL, CBC_OFF_CMD, CBC_OFF_LEN, CBC_OFF_RDADDR})) begin
      r_d.pslverr = 1'b1;
    end
    // Acquisition engine; bus commands take priority this cycle.
    if (!(wr_en && paddr_i == CBC_OFF_CMD)) begin
      case (r_q.st)
        CBC_ST_ARMED: begin
          if (fall && r_q.mode == CBC_MODE_TRIG) begin
            r_d.st = CBC_ST_REC;
            r_d.rec = 1'b1;
            r_d.trg = 1'b1;
          end else if (r_q.mode == CBC_MODE_SPT) begin
            r_d.st = CBC_ST_REC;
            r_d.rec = 1'b1;
            r_d.trg = 1'b1;
          end
        end
        CBC_ST_REC: begin
          // A stop edge acts even mid-sample, so a stop trigger is never lost to a busy cycle.
          if (r_q.mode == CBC_MODE_TRIG && r_q.circ && fall) begin
            r_d.st = CBC_ST_FILL;
          end else if (r_q.par == 3'h0 && ((r_q.mode == CBC_MODE_SPT) ? fall : tick)) begin
            r_d.hold = sample_i;
            r_d.pend = 1'b1;
            r_d.par = 3'h0;
          end
          if (r_q.pend) begin
            // Parameters of the held sample go out on back-to-back cycles.
            mem_we = 1'b1;
            mem_wd = r_q.hold.word[r_q.par[1:0]];
            r_d.par = r_q.par + 3'h1;
            r_d.bytes = r_q.bytes + 24'(CBC_BYTES_PER_POINT);
            if (r_q.circ && r_q.wrp && r_q.wptr[8:0] == 9'h0) begin
              // Overwriting a block retires its old bytes first, so the count never tops the length.
              r_d.bytes = r_q.bytes + 24'(CBC_BYTES_PER_POINT) - 24'(CBC_POINTS_PER_BLOCK * CBC_BYTES_PER_POINT);
            end
            if (r_q.par + 3'h1 == npar) begin
              r_d.pend = 1'b0;
              r_d.par = 3'h0;
            end
            r_d.wptr = r_q.wptr + 1'b1;
            if (buf_end) begin
              r_d.wptr = '0;
              r_d.wrp = 1'b1;
              if (!r_q.circ) begin
                r_d.st = CBC_ST_IDLE;
                r_d.rec = 1'b0;
                r_d.pend = 1'b0;
                r_d.par = 3'h0;
              end
            end
          end
        end
        CBC_ST_FILL: begin
          // Zero fill to the block edge; the real-byte count is left alone.
          r_d.pend = 1'b0;
          r_d.par = 3'h0;
          // A sample cut short by the stop is padded with zeros like the rest of the block.
          if (r_q.wptr[8:0] == 9'h0 && !(r_q.pend && r_q.par != 3'h0)) begin
            r_d.st = CBC_ST_IDLE;
            r_d.rec = 1'b0;
          end else begin
            mem_we = 1'b1;
            mem_wd = 32'h0;
            r_d.wptr = buf_end ? '0 : r_q.wptr + 1'b1;
            if (buf_end || blk_end) begin
              r_d.st = CBC_ST_IDLE;
              r_d.rec = 1'b0;
            end
          end
        end
        default: r_d.st = CBC_ST_IDLE;
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      r_q <= '0;
      r_q.len_kb <= CBC_LEN_RST_KB;
      r_q.trig_d <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // Sample storage; no reset so it maps onto plain storage.
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem_q[mem_wa] <= mem_wd;
    end
  end

  assign prdata_o = r_q.prdata;
  assign pready_o = r_q.pready;
  assign pslverr_o = r_q.pslverr;
  assign status_o = '{recording: r_q.rec, triggered: r_q.trg, wrapped: r_q.wrp};

  // Length register always holds an even value within range.
  a_len_even: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !r_q.len_kb[0] && r_q.len_kb <= CBC_LEN_MAX_KB && r_q.len_kb != 13'h0)
    else $error("buffer length not even or out of range");
  // Stop while armed returns to idle with no flags.
  a_armed_abort: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_en && paddr_i == CBC_OFF_CMD && pwdata_i[1:0] == 2'b10 && r_q.st == CBC_ST_ARMED
     && r_q.mode == CBC_MODE_TRIG) |=> (r_q.st == CBC_ST_IDLE && !r_q.trg))
    else $error("stop while armed did not abort");
  // Single-pass trigger never ends recording.
  a_trig_nostop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC && !r_q.circ && r_q.mode == CBC_MODE_TRIG && fall && !wr_en && !r_q.pend)
    |=> r_q.st == CBC_ST_REC)
    else $error("single-pass trigger stopped capture");
  // Circular trigger leads into zero fill.
  a_trig_stop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC && r_q.circ && r_q.mode == CBC_MODE_TRIG && fall && !wr_en)
    |=> r_q.st == CBC_ST_FILL)
    else $error("circular trigger did not stop");
  // Zero fill finishes within one block.
  a_fill_bound: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(r_q.st == CBC_ST_FILL) |-> ##[1:520] r_q.st == CBC_ST_IDLE)
    else $error("zero fill overran a block");
  // Fill writes zeros and leaves the byte count alone.
  a_fill_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_FILL && mem_we) |-> (mem_wd == 32'h0 && r_d.bytes == r_q.bytes))
    else $error("zero fill wrote data or counted bytes");
  // Start clears position and count.
  a_start_clr: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_en && paddr_i == CBC_OFF_CMD && pwdata_i[0]) |=> (r_q.bytes == 24'h0 && !r_q.wrp && r_q.wptr == '0))
    else $error("start did not clear capture");
  // Single-pass end sets wrapped and clears recording.
  a_full_stop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC && !r_q.circ && mem_we && buf_end && !wr_en) |=> (r_q.wrp && !r_q.rec))
    else $error("single-pass full did not stop");
  // Ready is a single-cycle pulse, so no access is acknowledged twice.
  a_ready_pulse: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.pready |=> !r_q.pready)
    else $error("pready stood for two cycles");
  // An error response only ever comes together with ready.
  a_err_ready: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.pslverr |-> r_q.pready)
    else $error("pslverr without pready");
  // Nothing shows in the state word while waiting for a start trigger.
  a_armed_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.st == CBC_ST_ARMED |-> (!r_q.rec && !r_q.trg && !r_q.wrp))
    else $error("state bits set while armed");
  // The recording bit follows the engine state.
  a_rec_flag: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC |-> r_q.rec) and (r_q.st == CBC_ST_IDLE |-> !r_q.rec))
    else $error("recording bit disagrees with state");
  // Immediate start records at once with the triggered bit set.
  a_imm_start: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (wr_en && paddr_i == CBC_OFF_CMD && pwdata_i[0] && r_q.mode == CBC_MODE_IMM)
    |=> (r_q.st == CBC_ST_REC && r_q.rec && r_q.trg))
    else $error("immediate start did not record");
  // Edges after an abort or after the end of a capture leave the engine idle.
  a_idle_deaf: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_IDLE && fall && !wr_en) |=> r_q.st == CBC_ST_IDLE)
    else $error("trigger edge left idle");
  // Each edge in per-trigger mode that finds no sample pending takes one sample set.
  a_spt_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC && r_q.mode == CBC_MODE_SPT && fall && !r_q.pend && !wr_en)
    |=> (r_q.pend && r_q.hold == $past(sample_i)))
    else $error("trigger edge took no sample");
  // Circular capture wraps to the start and marks the overwrite.
  a_circ_wrap: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_REC && r_q.circ && mem_we && buf_end && !wr_en && !fall)
    |=> (r_q.st == CBC_ST_REC && r_q.wptr == '0 && r_q.wrp))
    else $error("circular capture did not wrap");
  // The write position never leaves the programmed length while recording.
  a_wptr_range: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.st == CBC_ST_REC |-> (AW + 1)'(r_q.wptr) < len_words)
    else $error("write position beyond buffer length");
  // The real-byte count never exceeds the buffer, also once circular capture overwrites.
  a_bytes_bound: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.st == CBC_ST_REC |-> r_q.bytes <= 24'({r_q.len_kb, 10'h000}))
    else $error("byte count above buffer length");
  // Zero fill always ends on a block boundary.
  a_fill_align: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    (r_q.st == CBC_ST_FILL ##1 r_q.st == CBC_ST_IDLE) |-> r_q.wptr[8:0] == 9'h0)
    else $error("zero fill stopped inside a block");
  // Capture settings and the divisor stay frozen while a capture runs.
  a_cfg_frozen: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.st != CBC_ST_IDLE |=> ($stable(r_q.cfg) && $stable(r_q.mode) && $stable(r_q.circ)
    && $stable(r_q.div) && $stable(r_q.len_kb)))
    else $error("settings changed during capture");
  // The rate divisor never exceeds its limit.
  a_div_clamp: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    r_q.div <= CBC_DIV_MAX)
    else $error("rate divisor above limit");
endmodule

/* dv/cbc_src_model.sv */
`timescale 1ns/1ps
// Far-side model: lock-in sample source with its max-rate strobe, and the external trigger line.
module cbc_src_model #(
  parameter int STB_PERIOD = 3
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Trigger request from the bench.
  input wire logic fire_i,
  // Source outputs.
  output logic max_rate_stb_o = 1'b0,
  output cbc_pkg::cbc_sample_t sample_o,
  output logic trig_o = 1'b1
);
  import cbc_pkg::*;
  int div_q = 0;
  int low_q = 0;
  // Each lane carries its own float pattern so a stored word shows which lane it came from.
  assign sample_o = {32'h40800000, 32'h40400000, 32'h40000000, 32'h3F800000};
  // Strobe at the max rate; the trigger falls for four cycles, then returns to the pulled-up level.
  always @(posedge clk_sys_i) begin
    if (reset_i) begin
      div_q <= 0;
      low_q <= 0;
      max_rate_stb_o <= 1'b0;
      trig_o <= 1'b1;
    end else begin
      div_q <= (div_q == STB_PERIOD - 1) ? 0 : div_q + 1;
      max_rate_stb_o <= (div_q == 0);
      low_q <= fire_i ? 4 : (low_q != 0) ? low_q - 1 : 0;
      trig_o <= !(fire_i || low_q > 1);
    end
  end
endmodule

/* dv/capture_buffer_control_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; $display("BAD %0t mismatch got %0h want %0h", $time, (a), (b)); end end
module capture_buffer_control_tb;
  import cbc_pkg::*;
  logic clk_sys_i = 0, reset_i = 1, psel = 0, penable = 0, pwrite = 0, fire = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, stb, trig;
  cbc_sample_t sample;
  cbc_status_t status;
  int miscompares = 0, samples_checked = 0, cycles = 0;

  // A small depth keeps the capture memory cheap; every capture runs at the 2 kB length.
  cbc_capture_ctrl #(.DEPTH_WORDS(4096)) u_cbc_capture_ctrl (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .max_rate_stb_i(stb),
    .sample_i(sample), .external_trigger_input_i(trig), .status_o(status));
  cbc_src_model #(.STB_PERIOD(3)) u_cbc_src_model (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .fire_i(fire), .max_rate_stb_o(stb), .sample_o(sample), .trig_o(trig));

  // Free-running 25 MHz clock.
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // Hang guard, well above the longest expected run.
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task finish_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One APB transfer; pready and the answer are read just after each rising edge, as that edge sampled them.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task mem(input logic [31:0] idx, input logic [31:0] e);
    wr(CBC_OFF_RDADDR, idx);
    rdc(CBC_OFF_RDDATA, e);
  endtask

  task settle;
    repeat (2) @(negedge clk_sys_i);
  endtask

  task pulse_trig;
    @(posedge clk_sys_i);
    fire <= 1'b1;
    @(posedge clk_sys_i);
    fire <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
  endtask

  // Bounded wait for the recording flag to drop, zero fill included.
  task wait_idle;
    int n;
    n = 0;
    while (status.recording !== 1'b0 && n < 4000) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (status.recording !== 1'b0) begin
      miscompares++;
    end
  endtask

  task t_reset_len;
    `CHK(status, 3'b000)
    rdc(CBC_OFF_LEN, 32'h00000002);
    apb(1'b0, 12'hFFC, 32'h0);
    `CHK(err, 1'b1)
    wr(CBC_OFF_LEN, 32'h00000003);
    rdc(CBC_OFF_LEN, 32'h00000004);
    wr(CBC_OFF_LEN, 32'h00001388);
    rdc(CBC_OFF_LEN, 32'h00001000);
    wr(CBC_OFF_LEN, 32'h00000000);
    rdc(CBC_OFF_LEN, 32'h00000002);
    wr(CBC_OFF_CTRL, 32'h00000019 << CBC_CTRL_DIV_LSB);
    rdc(CBC_OFF_RATE, 32'h00000014);
  endtask

  task t_single_imm;
    wr(CBC_OFF_CTRL, 32'h00000000);
    wr(CBC_OFF_CMD, 32'h00000001);
    settle();
    `CHK(status, 3'b110)
    rdc(CBC_OFF_STAT, 32'h00000003);
    wait_idle();
    rdc(CBC_OFF_BYTES, 32'h00000800);
    rdc(CBC_OFF_STAT, 32'h00000006);
    mem(32'h00000000, 32'h3F800000);
    mem(32'h000001FF, 32'h3F800000);
    wr(CBC_OFF_CMD, 32'h00000001);
    settle();
    `CHK(status.wrapped, 1'b0)
    apb(1'b0, CBC_OFF_BYTES, 32'h0);
    `CHK(rd < 32'h00000100, 1'b1)
    wr(CBC_OFF_CMD, 32'h00000002);
    wait_idle();
  endtask

  task t_circ_wrap;
    wr(CBC_OFF_CTRL, 32'h00000001);
    wr(CBC_OFF_CMD, 32'h00000001);
    repeat (2000) @(posedge clk_sys_i);
    `CHK(status, 3'b111)
    wr(CBC_OFF_CMD, 32'h00000002);
    wait_idle();
    `CHK(status.recording, 1'b0)
    apb(1'b0, CBC_OFF_BYTES, 32'h0);
    `CHK(rd <= 32'h00000800 && rd != 32'h00000000, 1'b1)
  endtask

  task t_per_trig;
    wr(CBC_OFF_CTRL, (32'h2 << CBC_CTRL_MODE_LSB) | (32'h1 << CBC_CTRL_CFG_LSB));
    wr(CBC_OFF_CMD, 32'h00000001);
    repeat (3) pulse_trig();
    wr(CBC_OFF_CMD, 32'h00000002);
    wait_idle();
    rdc(CBC_OFF_BYTES, 32'h00000018);
    mem(32'h00000001, 32'h40000000);
    mem(32'h00000006, 32'h00000000);
  endtask

  task t_trig_start;
    wr(CBC_OFF_CTRL, 32'h1 << CBC_CTRL_MODE_LSB);
    wr(CBC_OFF_CMD, 32'h00000001);
    settle();
    `CHK(status, 3'b000)
    wr(CBC_OFF_CMD, 32'h00000002);
    pulse_trig();
    `CHK(status, 3'b000)
    wr(CBC_OFF_CMD, 32'h00000001);
    pulse_trig();
    `CHK(status, 3'b110)
    pulse_trig();
    `CHK(status.recording, 1'b1)
    wait_idle();
    rdc(CBC_OFF_BYTES, 32'h00000800);
  endtask

  task t_trig_stop;
    wr(CBC_OFF_CTRL, 32'h00000001 | (32'h1 << CBC_CTRL_MODE_LSB) | (32'h3 << CBC_CTRL_CFG_LSB));
    wr(CBC_OFF_CMD, 32'h00000001);
    settle();
    `CHK(status, 3'b110)
    repeat (60) @(posedge clk_sys_i);
    pulse_trig();
    wait_idle();
    `CHK(status.recording, 1'b0)
    `CHK(status, 3'b010)
    mem(32'h00000002, 32'h40400000);
  endtask

  // Main sequence: reset for six cycles, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    t_reset_len();
    t_single_imm();
    t_circ_wrap();
    t_per_trig();
    t_trig_start();
    t_trig_stop();
    finish_test();
  end
endmodule
